// ===== hdl/period_and_oneshot_counter.sv
// one counter channel: period measurement and one-shot pulse generation behind apb
`timescale 1ns/10ps
`default_nettype none
module period_and_oneshot_counter
  import ctr_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_measure_gate_input,
  input wire logic i_aux_clock_input,
  input wire logic i_trigger_input,
  output logic o_counter_out,
  output logic o_irq
);
  initial begin
    if (CNT_W != 32) begin
      $error("CNT_W must be 32");
    end
    // the output pulse counter is eight bits wide
    if (PULSE_CYC > 255) begin
      $error("pulse length does not fit its counter");
    end
    // the sampling strobe cannot run faster than the system clock
    if (CLK_HZ < SAMPLE_HZ) begin
      $error("system clock slower than sampling rate");
    end
  end

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARM = 4'b0010,
    ST_FIRST = 4'b0100,
    ST_SECOND = 4'b1000
  } state_t;

  logic [15:0] ctrl_q;
  logic glb_ien_q;
  logic [31:0] const_a_q;
  logic [31:0] const_b_q;
  logic [31:0] cnt_q;
  logic irq_pend_q;
  logic out_act_q;
  logic [7:0] pulse_cnt_q;
  state_t st_q;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] sacc_q;
  logic gate_s_q;
  logic trig_s_q;
  logic trig_prev_q;
  logic aux_prev_q;
  logic gate_prev_q;
  logic samp_q;
  state_t st_d;
  logic [31:0] cnt_d;
  logic [7:0] pulse_cnt_d;
  logic irq_pend_d;
  logic [15:0] ctrl_d;
  logic glb_ien_d;
  logic [31:0] const_a_d;
  logic [31:0] const_b_d;

  wire [2:0] mode = ctrl_q[MODE_LSB +: 3];
  wire [1:0] apol = ctrl_q[APOL_LSB +: 2];
  wire [1:0] bpol = ctrl_q[BPOL_LSB +: 2];
  wire [1:0] cpol = ctrl_q[CPOL_LSB +: 2];
  wire [2:0] csrc = ctrl_q[CSRC_LSB +: 3];
  wire opol = ctrl_q[OPOL_BIT];
  wire ien = ctrl_q[IEN_BIT];
  wire wide = ctrl_q[SIZE_BIT];
  wire [31:0] cnt_max = wide ? 32'hffffffff : 32'h0000ffff;

  wire apb_acc = i_psel && i_penable;
  wire apb_wr = apb_acc && i_pwrite;
  wire wr_ctrl = apb_wr && (i_paddr == ADDR_CTRL);
  wire wr_a = apb_wr && (i_paddr == ADDR_CONST_A);
  wire wr_b = apb_wr && (i_paddr == ADDR_CONST_B);
  wire wr_glb = apb_wr && (i_paddr == ADDR_GLOBAL);
  wire wr_irq = apb_wr && (i_paddr == ADDR_IRQ) && i_pwdata[0];
  wire wr_trig = apb_wr && (i_paddr == ADDR_TRIG) && i_pwdata[0];
  wire mapped = (i_paddr == ADDR_GLOBAL) || (i_paddr == ADDR_IRQ) || (i_paddr == ADDR_TRIG) ||
    (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_CONST_A) || (i_paddr == ADDR_CONST_B) ||
    (i_paddr == ADDR_READBACK);

  // 20 MHz sampling strobe for gate and trigger inputs
  wire [ACC_W-1:0] sacc_sum = sacc_q + STEP_20M;
  wire samp_tick = sacc_sum >= ACC_MOD;
  wire [ACC_W-1:0] sacc_d = samp_tick ? sacc_sum - ACC_MOD : sacc_sum;

  // internal clock select: rate = 20 MHz >> (4 - code)
  wire [2:0] shift = (csrc <= 3'h4) ? 3'h4 - csrc : 3'h0;
  wire [ACC_W-1:0] step_sel = STEP_20M >> shift;
  wire [ACC_W-1:0] acc_sum = acc_q + step_sel;
  wire int_tick = acc_sum >= ACC_MOD;
  wire [ACC_W-1:0] acc_d = int_tick ? acc_sum - ACC_MOD : acc_sum;
  wire ext_sel = (csrc == CSRC_EXT) && (bpol == POL_LOW || bpol == POL_HIGH);
  wire ext_tick = ext_sel && i_aux_clock_input && !aux_prev_q;
  wire clk_tick = (csrc == CSRC_EXT) ? ext_tick : (csrc <= 3'h4) && int_tick;

  // gate level counted as active
  wire in_act = (apol == POL_LOW) ? !gate_s_q : gate_s_q;
  wire in_en = (apol == POL_LOW) || (apol == POL_HIGH);
  wire trig_lvl = (cpol == POL_LOW) ? !trig_s_q : trig_s_q;
  wire trig_lvl_prev = (cpol == POL_LOW) ? !trig_prev_q : trig_prev_q;
  // samp_q limits each sampled edge to one cycle even when strobes are two cycles apart
  wire ext_trig = samp_q && (cpol == POL_LOW || cpol == POL_HIGH) && trig_lvl && !trig_lvl_prev;
  wire trigger = wr_trig || ext_trig;
  wire gate_prev_act = (apol == POL_LOW) ? !gate_prev_q : gate_prev_q;
  wire act_start = samp_q && in_en && in_act && !gate_prev_act;
  wire [31:0] wdata_sized = wide ? i_pwdata : {16'h0, i_pwdata[15:0]};
  wire setup_ph = i_psel && !i_penable;
  wire [31:0] prdata_d = (setup_ph && !i_pwrite) ? rd_mux_w : 32'h0;
  wire is_period = mode == MODE_PERIOD;
  wire is_oneshot = mode == MODE_ONESHOT;
  wire os_run = !in_en || in_act;
  wire [31:0] cnt_inc = (cnt_q >= cnt_max) ? cnt_max : cnt_q + 32'h1;
  wire meas_done = is_period && (st_q == ST_SECOND) && act_start;
  wire os_edge = is_oneshot && (st_q == ST_FIRST || st_q == ST_SECOND) && os_run && clk_tick &&
    (cnt_q == 32'h0);
  wire irq_event = meas_done || os_edge;
  wire [31:0] rd_ctrl = {16'h0, ctrl_q & CTRL_WR_MASK};
  wire [31:0] rd_mux_w = (i_paddr == ADDR_CTRL) ? rd_ctrl :
    (i_paddr == ADDR_GLOBAL) ? {31'h0, glb_ien_q} :
    (i_paddr == ADDR_IRQ) ? {31'h0, irq_pend_q} :
    (i_paddr == ADDR_CONST_A) ? const_a_q :
    (i_paddr == ADDR_CONST_B) ? const_b_q :
    (i_paddr == ADDR_READBACK) ? (cnt_q & cnt_max) : 32'h0;
  wire os_level = (st_q == ST_SECOND) && is_oneshot;
  wire out_lvl = is_oneshot ? os_level : (pulse_cnt_q != 8'h0);

  // apb: zero wait state, slverr on unmapped addresses
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      o_pready <= setup_ph;
      o_pslverr <= setup_ph && !mapped;
      o_prdata <= prdata_d;
    end
  end

  // register writes take effect only at the edge that ends the access phase
  always_comb begin
    ctrl_d = ctrl_q;
    glb_ien_d = glb_ien_q;
    const_a_d = const_a_q;
    const_b_d = const_b_q;
    if (o_pready) begin
      if (wr_ctrl) begin
        ctrl_d = i_pwdata[15:0] & CTRL_WR_MASK;
      end
      if (wr_a) begin
        const_a_d = wdata_sized;
      end
      if (wr_b) begin
        const_b_d = wdata_sized;
      end
      if (wr_glb) begin
        glb_ien_d = i_pwdata[0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q <= CTRL_RESET;
      glb_ien_q <= 1'b0;
      const_a_q <= 32'h0;
      const_b_q <= 32'h0;
    end else if (i_ce) begin
      ctrl_q <= ctrl_d;
      glb_ien_q <= glb_ien_d;
      const_a_q <= const_a_d;
      const_b_q <= const_b_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sacc_q <= '0;
      acc_q <= '0;
      gate_s_q <= 1'b0;
      gate_prev_q <= 1'b0;
      trig_s_q <= 1'b0;
      trig_prev_q <= 1'b0;
      aux_prev_q <= 1'b0;
      samp_q <= 1'b0;
    end else if (i_ce) begin
      sacc_q <= sacc_d;
      samp_q <= samp_tick;
      acc_q <= acc_d;
      aux_prev_q <= i_aux_clock_input;
      if (samp_tick) begin
        gate_s_q <= i_measure_gate_input;
        gate_prev_q <= gate_s_q;
        trig_s_q <= i_trigger_input;
        trig_prev_q <= trig_s_q;
      end
    end
  end

  // sequencer: period uses ARM(wait active start) then SECOND(count until next start)
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    if (trigger && is_period) begin
      st_d = ST_ARM;
      cnt_d = 32'h0;
    end else if (trigger && is_oneshot) begin
      st_d = ST_FIRST;
      cnt_d = const_a_q;
    end else if (wr_a && o_pready) begin
      // the freshly written constant, not the old one, lands in the counter
      cnt_d = wdata_sized;
    end else if (is_period) begin
      unique case (st_q)
        ST_ARM: begin
          if (act_start) begin
            st_d = ST_SECOND;
          end
        end
        ST_SECOND: begin
          if (act_start) begin
            st_d = ST_IDLE;
          end else if (clk_tick) begin
            cnt_d = cnt_inc;
          end
        end
        default: begin
          st_d = st_q;
        end
      endcase
    end else if (is_oneshot && os_run && clk_tick) begin
      unique case (st_q)
        ST_FIRST: begin
          if (cnt_q == 32'h0) begin
            st_d = ST_SECOND;
            cnt_d = const_b_q;
          end else begin
            cnt_d = cnt_q - 32'h1;
          end
        end
        ST_SECOND: begin
          if (cnt_q == 32'h0) begin
            st_d = ST_IDLE;
          end else begin
            cnt_d = cnt_q - 32'h1;
          end
        end
        default: begin
          st_d = st_q;
        end
      endcase
    end else if (!is_period && !is_oneshot) begin
      st_d = ST_IDLE;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= ST_IDLE;
      cnt_q <= 32'h0;
    end else if (i_ce) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  always_comb begin
    pulse_cnt_d = pulse_cnt_q;
    irq_pend_d = irq_pend_q;
    if (meas_done) begin
      pulse_cnt_d = 8'(PULSE_CYC);
    end else if (pulse_cnt_q != 8'h0) begin
      pulse_cnt_d = pulse_cnt_q - 8'h1;
    end
    // set wins over clear
    if (irq_event && ien) begin
      irq_pend_d = 1'b1;
    end else if (!ien || (wr_irq && o_pready)) begin
      irq_pend_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pulse_cnt_q <= 8'h0;
      irq_pend_q <= 1'b0;
      o_counter_out <= 1'b1;
      o_irq <= 1'b0;
    end else if (i_ce) begin
      pulse_cnt_q <= pulse_cnt_d;
      irq_pend_q <= irq_pend_d;
      o_counter_out <= opol ? out_lvl : !out_lvl;
      o_irq <= irq_pend_q && glb_ien_q;
    end
  end
endmodule
`default_nettype wire

// ===== pkg/ctr_pkg.sv
// shared constants for the period and one-shot counter channel
package ctr_pkg;
  localparam logic [7:0] ADDR_GLOBAL = 8'h00;
  localparam logic [7:0] ADDR_IRQ = 8'h04;
  localparam logic [7:0] ADDR_TRIG = 8'h34;
  localparam logic [7:0] ADDR_CTRL = 8'h38;
  localparam logic [7:0] ADDR_CONST_A = 8'h50;
  localparam logic [7:0] ADDR_CONST_B = 8'h58;
  localparam logic [7:0] ADDR_READBACK = 8'h48;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WR_MASK = 16'hdfff;
  localparam int MODE_LSB = 0;
  localparam int OPOL_BIT = 3;
  localparam int APOL_LSB = 4;
  localparam int BPOL_LSB = 6;
  localparam int CPOL_LSB = 8;
  localparam int CSRC_LSB = 10;
  localparam int SIZE_BIT = 14;
  localparam int IEN_BIT = 15;
  localparam logic [2:0] MODE_PERIOD = 3'h6;
  localparam logic [2:0] MODE_ONESHOT = 3'h7;
  localparam logic [1:0] POL_LOW = 2'h1;
  localparam logic [1:0] POL_HIGH = 2'h2;
  localparam logic [2:0] CSRC_EXT = 3'h5;
  localparam int CLK_HZ = 25000000;
  localparam int PULSE_NS = 1600;
  localparam int PULSE_CYC = (PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int SAMPLE_HZ = 20000000;
  // internal rate divisors, selected clock ticks counted in a 25 MHz phase accumulator
  localparam int ACC_W = 26;
  localparam logic [ACC_W-1:0] STEP_20M = ACC_W'(20000000);
  localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_HZ);
endpackage

// ===== verif/period_and_oneshot_counter_props.sv
// port assertions for the counter channel
`timescale 1ns/10ps
`default_nettype none
module period_and_oneshot_counter_props
  import ctr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic gen_q;
  wire logic wr_w;
  assign wr_w = o_pready && i_psel && i_pwrite;
  // shadow of the global interrupt enable
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gen_q <= 1'b0;
    end else if (wr_w && i_paddr == ADDR_GLOBAL) begin
      gen_q <= i_pwdata[0];
    end
  end
  sequence setup_s;
    i_ce && i_psel && !i_penable;
  endsequence
  a_ready_after_setup: assert property (setup_s |=> o_pready) else $error("ready missing");
  a_no_stray_ready: assert property (i_ce && !(i_psel && !i_penable) |=> !o_pready) else $error("stray ready");
  a_err_needs_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
  a_idle_data_zero: assert property (!o_pready |-> o_prdata == 32'h0) else $error("data not zero");
  a_unmapped_err: assert property (o_pready && i_paddr == 8'h0c |-> o_pslverr) else $error("unmapped taken");
  a_bit13_zero: assert property (o_pready && !i_pwrite && i_paddr == ADDR_CTRL |-> !o_prdata[13])
    else $error("bit 13 set");
  a_irq_global: assert property (o_irq |-> gen_q || $past(gen_q))
    else $error("irq without enable");
  a_ien_clear: assert property (wr_w && i_paddr == ADDR_CTRL && !i_pwdata[IEN_BIT] |=> ##2 !o_irq)
    else $error("irq kept");
endmodule
bind period_and_oneshot_counter period_and_oneshot_counter_props chk_u (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq));
`default_nettype wire

// ===== verif/signal_source.sv
// far side model: gate square wave, aux clock bursts, trigger pulses
`timescale 1ns/10ps
`default_nettype none
module signal_source #(
  parameter int HALF = 20
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_aux_run,
  input wire logic i_fire,
  output logic o_gate,
  output logic o_aux,
  output logic o_trig
);
  int gate_q;
  int trig_q;
  logic [1:0] div_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gate_q <= 0;
      trig_q <= 0;
      div_q <= 2'h0;
    end else begin
      gate_q <= (gate_q + 1) % (2 * HALF);
      div_q <= i_aux_run ? div_q + 2'h1 : 2'h0;
      trig_q <= i_fire ? 4 : (trig_q > 0 ? trig_q - 1 : 0);
    end
  end
  assign o_gate = gate_q >= HALF;
  // aux clock stands low unless a burst is asked for
  assign o_aux = div_q[1];
  assign o_trig = trig_q > 0;
endmodule
`default_nettype wire

// ===== verif/tb_period_and_oneshot_counter.sv
// self-checking bench for the counter channel
`timescale 1ns/10ps
`default_nettype none
module tb_period_and_oneshot_counter
  import ctr_pkg::*;
  ;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic aux_run = 1'b0;
  logic fire = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, gate, aux, trig, cout, irq, prev, err;
  logic [31:0] pcfg [2] = '{32'h9026, 32'h9466};
  int plo [2] = '{31, 0};
  int phi [2] = '{33, 0};
  int fails = 0;
  int num_checks = 0;
  int run = 0;
  int last = 0;
  int n;
  always #20 clk = ~clk;
  period_and_oneshot_counter #(.CNT_W(32)) dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_measure_gate_input(gate), .i_aux_clock_input(aux),
    .i_trigger_input(trig), .o_counter_out(cout), .o_irq(irq));
  signal_source src_u (.i_clk(clk), .i_rst_b(rst_b), .i_aux_run(aux_run), .i_fire(fire), .o_gate(gate),
    .o_aux(aux), .o_trig(trig));
  // length of the previous steady run of the output pin
  always @(negedge clk) begin
    if (cout !== prev) begin
      last = run;
      run = 1;
    end else begin
      run = run + 1;
    end
    prev = cout;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: %s got %h", $time, m, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    ok = 1'b0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(negedge clk);
      ok = (pready === 1'b1);
      rd = prdata;
      err = pslverr;
      @(posedge clk);
    end
    psel <= 1'b0;
    pen <= 1'b0;
    if (!ok) begin
      fails++;
      test_done();
    end
    @(posedge clk);
  endtask
  task automatic wait_out(input logic v);
    for (n = 0; n < 3000 && cout !== v; n++) @(negedge clk);
    if (cout !== v) begin
      fails++;
      test_done();
    end
    @(negedge clk);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk(cout, 1, "idle out");
    chk(irq, 0, "idle irq");
    @(posedge clk);
    apb(0, ADDR_CTRL, 0);
    chk(rd, CTRL_RESET, "ctrl reset");
    apb(1, ADDR_CTRL, 32'hffff);
    apb(0, ADDR_CTRL, 0);
    chk(rd, 32'hdfff, "ctrl read");
    apb(0, 8'h0c, 0);
    chk({rd[30:0], err}, 1, "unmapped");
    apb(1, ADDR_CTRL, 0);
    apb(1, ADDR_GLOBAL, 1);
    $display("register test done");
    foreach (pcfg[i]) begin
      apb(1, ADDR_CTRL, pcfg[i]);
      apb(1, ADDR_TRIG, 1);
      wait_out(0);
      wait_out(1);
      chk(last, PULSE_CYC, "pulse width");
      apb(0, ADDR_READBACK, 0);
      chk(rd >= plo[i] && rd <= phi[i], 1, "period count");
      chk(irq, 1, "period irq");
      apb(1, ADDR_IRQ, 1);
      @(negedge clk);
      chk(irq, 0, "irq clear");
      $display("period test done");
    end
    apb(1, ADDR_CONST_A, 10);
    apb(1, ADDR_CONST_B, 20);
    apb(1, ADDR_CTRL, 32'h964f);
    aux_run <= 1'b1;
    repeat (2) begin
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      wait_out(1);
      chk(n >= 40 && n <= 56, 1, "delay");
      @(negedge clk);
      chk(irq, 1, "rise irq");
      apb(1, ADDR_IRQ, 1);
      @(negedge clk);
      chk(irq, 0, "irq clear");
      wait_out(0);
      chk(last >= 80 && last <= 88, 1, "width");
      repeat (3) @(negedge clk);
      chk(irq, 1, "fall irq");
      apb(1, ADDR_IRQ, 1);
      $display("one-shot test done");
    end
    test_done();
  end
endmodule
`default_nettype wire
